// ===== rtl/mrab_bridge.sv
// What this block does
// - rms, irq, samples direct; rest via pointer
// - irq bytes latched individually when read
// - high byte read latches whole 24-bit value
// - low/mid before high give old value
// - pointer write launches one indirect access
// - pointer bit 7 write, bits 6:0 address
// - write access sends low, mid, high bytes
// - one-byte register write uses low only
// - read access loads three data bytes
// - one-byte register read zeroes mid, high
// - metering side slower; crossing needs synchronising
// - least significant byte sits in low
// - data bytes at 0x92 to 0x94
// - rms bytes read-only at D1-D6
// - irq enable word at D9 to DB
// - irq status word at DC to DE
// - sample bytes read-only E2 to E7
// - seven-bit internal address, zero reserved
module mrab_bridge (
    input wire logic clk,
    input wire logic reset_n,
    input wire mrab_pkg::mrab_sfr_type sfr_in,
    output logic [7:0] sfr_rdata_r,
    output logic meter_req_r,
    output mrab_pkg::mrab_cmd_type meter_cmd_r,
    input wire logic meter_ack,
    input wire logic [23:0] meter_rdata,
    input wire mrab_pkg::mrab_live_type meter_live,
    output mrab_pkg::mrab_irq_wr_type irq_wr_r
);
    import mrab_pkg::*;

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------

    // true for internal registers that are only one byte wide
    function automatic logic is_byte_reg(input logic [6:0] a);
        is_byte_reg = (a >= BYTE_REG_CFG_FIRST && a <= BYTE_REG_CFG_LAST)
            || (a == BYTE_REG_DIP_CYCLES) || (a == BYTE_REG_GAIN)
            || (a >= BYTE_REG_DIV_FIRST && a <= BYTE_REG_DIV_LAST);
    endfunction

    // picks one byte lane out of a 24-bit word
    function automatic logic [7:0] lane_of(input logic [23:0] w,
                                           input logic [1:0] lane);
        lane_of = w[{lane, 3'b000} +: 8];
    endfunction

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    mrab_state_type state_r; // handshake sequencer
    logic [7:0] pointer_r; // last pointer value written
    logic [7:0] data_low_r; // indirect data bytes
    logic [7:0] data_mid_r;
    logic [7:0] data_high_r;
    logic [23:0] vrms_lat_r; // captured rms and samples
    logic [23:0] irms_lat_r;
    logic [23:0] wav1_lat_r;
    logic [23:0] wav2_lat_r;
    logic [23:0] irqen_lat_r; // per-byte captured irq words
    logic [23:0] irqst_lat_r;
    logic ack_meta_r; // first synchroniser stages
    logic [23:0] rdata_meta_r;
    mrab_live_type live_meta_r;
    logic ack_sync_r; // second synchroniser stages
    logic [23:0] rdata_sync_r;
    mrab_live_type live_sync_r;
    logic [6:0] cmd_addr; // address field of pointer write
    logic launch; // pointer write that starts an access
    logic done; // read or write access acknowledged
    logic ptr_wr; // software writes the pointer
    logic [1:0] en_lane; // byte lane of an enable word access
    logic [1:0] st_lane; // byte lane of a status word access

    assign ptr_wr = sfr_in.wr && (sfr_in.addr == ADDR_POINTER);
    assign cmd_addr = sfr_in.wdata[6:0];
    // reserved internal address and a busy bridge both drop the launch
    assign launch = ptr_wr && (state_r == ST_IDLE)
        && (cmd_addr != INT_ADDR_RESERVED);
    assign done = (state_r == ST_REQ) && ack_sync_r;
    // enable bytes sit one above a lane boundary, status bytes on it
    assign en_lane = sfr_in.addr[1:0] - 2'h1;
    assign st_lane = sfr_in.addr[1:0];

    // ------------------------------------------------------------------
    // synchronisers from the metering domain
    // ------------------------------------------------------------------

    // the metering processor runs on a far slower clock, so every
    // level it drives is passed through two flops before use
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ack_meta_r <= 1'b0;
            ack_sync_r <= 1'b0;
            rdata_meta_r <= WORD_RESET;
            rdata_sync_r <= WORD_RESET;
            live_meta_r <= '0;
            live_sync_r <= '0;
        end else begin
            ack_meta_r <= meter_ack;
            ack_sync_r <= ack_meta_r;
            rdata_meta_r <= meter_rdata;
            rdata_sync_r <= rdata_meta_r;
            live_meta_r <= meter_live;
            live_sync_r <= live_meta_r;
        end
    end

    // ------------------------------------------------------------------
    // indirect access handshake
    // ------------------------------------------------------------------

    // four-phase request and acknowledge; a launch while busy is
    // dropped, which is why software must wait between accesses
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_r <= ST_IDLE;
            meter_req_r <= 1'b0;
        end else begin
            unique case (state_r)
                // waiting for software to write the pointer
                ST_IDLE: begin
                    if (launch) begin
                        state_r <= ST_REQ;
                        meter_req_r <= 1'b1;
                    end
                end
                // request held until the far side answers
                ST_REQ: begin
                    if (ack_sync_r) begin
                        state_r <= ST_DROP;
                        meter_req_r <= 1'b0;
                    end
                end
                // wait for acknowledge to fall before the next access
                ST_DROP: begin
                    if (!ack_sync_r) begin
                        state_r <= ST_IDLE;
                    end
                end
                // unused code falls back to idle
                default: begin
                    state_r <= ST_IDLE;
                    meter_req_r <= 1'b0;
                end
            endcase
        end
    end

    // command word held stable for the whole handshake
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            meter_cmd_r <= '0;
        end else if (launch) begin
            meter_cmd_r.write <= sfr_in.wdata[PTR_DIR_BIT];
            meter_cmd_r.addr <= cmd_addr;
            // one-byte targets get only the low byte; upper lanes zero
            if (is_byte_reg(cmd_addr)) begin
                meter_cmd_r.wdata <= {16'h0000, data_low_r};
            end else begin
                meter_cmd_r.wdata <= {data_high_r, data_mid_r,
                                      data_low_r};
            end
        end
    end

    // pointer register keeps whatever software last wrote
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pointer_r <= BYTE_RESET;
        end else if (ptr_wr) begin
            pointer_r <= sfr_in.wdata;
        end
    end

    // ------------------------------------------------------------------
    // indirect data bytes
    // ------------------------------------------------------------------

    // a completing read overrides a software write in the same cycle;
    // software is expected to wait, so the clash only hits bad code
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            data_low_r <= BYTE_RESET;
            data_mid_r <= BYTE_RESET;
            data_high_r <= BYTE_RESET;
        end else if (done && !meter_cmd_r.write) begin
            data_low_r <= rdata_sync_r[7:0];
            if (is_byte_reg(meter_cmd_r.addr)) begin
                data_mid_r <= BYTE_RESET;
                data_high_r <= BYTE_RESET;
            end else begin
                data_mid_r <= rdata_sync_r[15:8];
                data_high_r <= rdata_sync_r[23:16];
            end
        end else if (sfr_in.wr) begin
            // software side of the data bytes
            if (sfr_in.addr == ADDR_DATA_LOW) begin
                data_low_r <= sfr_in.wdata;
            end
            if (sfr_in.addr == ADDR_DATA_MID) begin
                data_mid_r <= sfr_in.wdata;
            end
            if (sfr_in.addr == ADDR_DATA_HIGH) begin
                data_high_r <= sfr_in.wdata;
            end
        end
    end

    // ------------------------------------------------------------------
    // rms and sample capture
    // ------------------------------------------------------------------

    // only a high-byte read refreshes a group, so the low and middle
    // bytes that follow come from the same instant
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            vrms_lat_r <= WORD_RESET;
            irms_lat_r <= WORD_RESET;
            wav1_lat_r <= WORD_RESET;
            wav2_lat_r <= WORD_RESET;
        end else if (sfr_in.rd) begin
            if (sfr_in.addr == ADDR_VRMS_HIGH) begin
                vrms_lat_r <= live_sync_r.vrms;
            end
            if (sfr_in.addr == ADDR_IRMS_HIGH) begin
                irms_lat_r <= live_sync_r.irms;
            end
            if (sfr_in.addr == ADDR_WAV1_HIGH) begin
                wav1_lat_r <= live_sync_r.wav1;
            end
            if (sfr_in.addr == ADDR_WAV2_HIGH) begin
                wav2_lat_r <= live_sync_r.wav2;
            end
        end
    end

    // ------------------------------------------------------------------
    // interrupt enable and status bytes
    // ------------------------------------------------------------------

    // each byte is captured on its own read; a write leaves the copy
    // untouched and only goes out as a strobe to the metering side
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            irqen_lat_r <= WORD_RESET;
            irqst_lat_r <= WORD_RESET;
        end else if (sfr_in.rd) begin
            unique case (sfr_in.addr)
                ADDR_IRQEN_LOW, ADDR_IRQEN_MID, ADDR_IRQEN_HIGH: begin
                    irqen_lat_r[{en_lane, 3'b000} +: 8]
                        <= lane_of(live_sync_r.irq_en, en_lane);
                end
                ADDR_IRQST_LOW, ADDR_IRQST_MID, ADDR_IRQST_HIGH: begin
                    irqst_lat_r[{st_lane, 3'b000} +: 8]
                        <= lane_of(live_sync_r.irq_st, st_lane);
                end
                default: begin
                end
            endcase
        end
    end

    // byte writes to the interrupt words go out as one-cycle strobes
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            irq_wr_r <= '0;
        end else begin
            irq_wr_r.valid <= 1'b0;
            if (sfr_in.wr) begin
                irq_wr_r.data <= sfr_in.wdata;
                unique case (sfr_in.addr)
                    ADDR_IRQEN_LOW, ADDR_IRQEN_MID, ADDR_IRQEN_HIGH: begin
                        irq_wr_r.valid <= 1'b1;
                        irq_wr_r.to_status <= 1'b0;
                        irq_wr_r.lane <= en_lane;
                    end
                    ADDR_IRQST_LOW, ADDR_IRQST_MID, ADDR_IRQST_HIGH: begin
                        irq_wr_r.valid <= 1'b1;
                        irq_wr_r.to_status <= 1'b1;
                        irq_wr_r.lane <= st_lane;
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------------
    // read data
    // ------------------------------------------------------------------

    // read answer one cycle after the strobe; unmapped reads give zero
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sfr_rdata_r <= BYTE_RESET;
        end else if (sfr_in.rd) begin
            unique case (sfr_in.addr)
                ADDR_POINTER: sfr_rdata_r <= pointer_r;
                ADDR_DATA_LOW: sfr_rdata_r <= data_low_r;
                ADDR_DATA_MID: sfr_rdata_r <= data_mid_r;
                ADDR_DATA_HIGH: sfr_rdata_r <= data_high_r;
                // low and middle bytes come from the old capture
                ADDR_VRMS_LOW: sfr_rdata_r <= vrms_lat_r[7:0];
                ADDR_VRMS_MID: sfr_rdata_r <= vrms_lat_r[15:8];
                ADDR_VRMS_HIGH: sfr_rdata_r <= live_sync_r.vrms[23:16];
                ADDR_IRMS_LOW: sfr_rdata_r <= irms_lat_r[7:0];
                ADDR_IRMS_MID: sfr_rdata_r <= irms_lat_r[15:8];
                ADDR_IRMS_HIGH: sfr_rdata_r <= live_sync_r.irms[23:16];
                ADDR_WAV1_LOW: sfr_rdata_r <= wav1_lat_r[7:0];
                ADDR_WAV1_MID: sfr_rdata_r <= wav1_lat_r[15:8];
                ADDR_WAV1_HIGH: sfr_rdata_r <= live_sync_r.wav1[23:16];
                ADDR_WAV2_LOW: sfr_rdata_r <= wav2_lat_r[7:0];
                ADDR_WAV2_MID: sfr_rdata_r <= wav2_lat_r[15:8];
                ADDR_WAV2_HIGH: sfr_rdata_r <= live_sync_r.wav2[23:16];
                // interrupt bytes answer with the value caught now
                ADDR_IRQEN_LOW, ADDR_IRQEN_MID, ADDR_IRQEN_HIGH:
                    sfr_rdata_r <= lane_of(live_sync_r.irq_en,
                                           en_lane);
                ADDR_IRQST_LOW, ADDR_IRQST_MID, ADDR_IRQST_HIGH:
                    sfr_rdata_r <= lane_of(live_sync_r.irq_st,
                                           st_lane);
                default: sfr_rdata_r <= BYTE_RESET;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------

    a_launch_req: assert property (
        @(posedge clk) disable iff (!reset_n)
        launch |=> meter_req_r && state_r == ST_REQ)
        else $error("pointer write did not raise request");

    a_reserved_drop: assert property (
        @(posedge clk) disable iff (!reset_n)
        (ptr_wr && state_r == ST_IDLE && cmd_addr == INT_ADDR_RESERVED)
        |=> !meter_req_r)
        else $error("reserved address launched an access");

    a_dir_addr: assert property (
        @(posedge clk) disable iff (!reset_n)
        launch |=> meter_cmd_r.write == $past(sfr_in.wdata[7])
            && meter_cmd_r.addr == $past(sfr_in.wdata[6:0]))
        else $error("command direction or address wrong");

    a_byte_mask: assert property (
        @(posedge clk) disable iff (!reset_n)
        $rose(meter_req_r) && is_byte_reg(meter_cmd_r.addr)
        |-> meter_cmd_r.wdata[23:8] == 16'h0000)
        else $error("one-byte write carried upper bytes");

    a_req_hold: assert property (
        @(posedge clk) disable iff (!reset_n)
        meter_req_r && !ack_sync_r |=> meter_req_r && $stable(meter_cmd_r))
        else $error("request dropped before acknowledge");

    a_read_zero: assert property (
        @(posedge clk) disable iff (!reset_n)
        done && !meter_cmd_r.write && is_byte_reg(meter_cmd_r.addr)
        |=> data_mid_r == BYTE_RESET && data_high_r == BYTE_RESET)
        else $error("one-byte read left upper bytes set");

    a_read_fill: assert property (
        @(posedge clk) disable iff (!reset_n)
        done && !meter_cmd_r.write
        |=> data_low_r == $past(rdata_sync_r[7:0]))
        else $error("read result not loaded");

    a_high_latch: assert property (
        @(posedge clk) disable iff (!reset_n)
        sfr_in.rd && sfr_in.addr == ADDR_VRMS_HIGH
        |=> vrms_lat_r == $past(live_sync_r.vrms)
            && sfr_rdata_r == $past(live_sync_r.vrms[23:16]))
        else $error("high byte read did not capture word");

    a_low_old: assert property (
        @(posedge clk) disable iff (!reset_n)
        sfr_in.rd && sfr_in.addr == ADDR_IRMS_LOW
        |=> $stable(irms_lat_r) && sfr_rdata_r == irms_lat_r[7:0])
        else $error("low byte read disturbed capture");

    a_irq_byte: assert property (
        @(posedge clk) disable iff (!reset_n)
        sfr_in.rd && sfr_in.addr == ADDR_IRQST_MID
        |=> irqst_lat_r[15:8] == $past(live_sync_r.irq_st[15:8])
            && $stable(irqst_lat_r[7:0]))
        else $error("status byte not captured alone");

    a_irqen_byte: assert property (
        @(posedge clk) disable iff (!reset_n)
        sfr_in.rd && sfr_in.addr == ADDR_IRQEN_HIGH
        |=> irqen_lat_r[23:16] == sfr_rdata_r
            && sfr_rdata_r == $past(live_sync_r.irq_en[23:16]))
        else $error("enable byte not captured on read");

endmodule

// ===== rtl/mrab_pkg.sv
package mrab_pkg;

    // ------------------------------------------------------------------
    // special function register addresses
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_POINTER = 8'h91;
    localparam logic [7:0] ADDR_DATA_LOW = 8'h92;
    localparam logic [7:0] ADDR_DATA_MID = 8'h93;
    localparam logic [7:0] ADDR_DATA_HIGH = 8'h94;
    localparam logic [7:0] ADDR_VRMS_LOW = 8'hD1;
    localparam logic [7:0] ADDR_VRMS_MID = 8'hD2;
    localparam logic [7:0] ADDR_VRMS_HIGH = 8'hD3;
    localparam logic [7:0] ADDR_IRMS_LOW = 8'hD4;
    localparam logic [7:0] ADDR_IRMS_MID = 8'hD5;
    localparam logic [7:0] ADDR_IRMS_HIGH = 8'hD6;
    localparam logic [7:0] ADDR_IRQEN_LOW = 8'hD9;
    localparam logic [7:0] ADDR_IRQEN_MID = 8'hDA;
    localparam logic [7:0] ADDR_IRQEN_HIGH = 8'hDB;
    localparam logic [7:0] ADDR_IRQST_LOW = 8'hDC;
    localparam logic [7:0] ADDR_IRQST_MID = 8'hDD;
    localparam logic [7:0] ADDR_IRQST_HIGH = 8'hDE;
    localparam logic [7:0] ADDR_WAV1_LOW = 8'hE2;
    localparam logic [7:0] ADDR_WAV1_MID = 8'hE3;
    localparam logic [7:0] ADDR_WAV1_HIGH = 8'hE4;
    localparam logic [7:0] ADDR_WAV2_LOW = 8'hE5;
    localparam logic [7:0] ADDR_WAV2_MID = 8'hE6;
    localparam logic [7:0] ADDR_WAV2_HIGH = 8'hE7;

    // ------------------------------------------------------------------
    // pointer layout and internal page
    // ------------------------------------------------------------------
    localparam int PTR_DIR_BIT = 7;
    localparam logic [6:0] INT_ADDR_RESERVED = 7'h00;
    // one-byte internal registers of the metering page
    localparam logic [6:0] BYTE_REG_CFG_FIRST = 7'h0B;
    localparam logic [6:0] BYTE_REG_CFG_LAST = 7'h10;
    localparam logic [6:0] BYTE_REG_DIP_CYCLES = 7'h13;
    localparam logic [6:0] BYTE_REG_GAIN = 7'h1B;
    localparam logic [6:0] BYTE_REG_DIV_FIRST = 7'h24;
    localparam logic [6:0] BYTE_REG_DIV_LAST = 7'h26;

    // ------------------------------------------------------------------
    // byte lanes and reset values
    // ------------------------------------------------------------------
    localparam logic [1:0] LANE_LOW = 2'h0;
    localparam logic [1:0] LANE_MID = 2'h1;
    localparam logic [1:0] LANE_HIGH = 2'h2;
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic [23:0] WORD_RESET = 24'h000000;

    // ------------------------------------------------------------------
    // types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_REQ = 2'b01,
        ST_DROP = 2'b10
    } mrab_state_type;

    typedef struct packed {
        logic [7:0] addr;
        logic wr;
        logic rd;
        logic [7:0] wdata;
    } mrab_sfr_type;

    typedef struct packed {
        logic write;
        logic [6:0] addr;
        logic [23:0] wdata;
    } mrab_cmd_type;

    typedef struct packed {
        logic [23:0] vrms;
        logic [23:0] irms;
        logic [23:0] irq_en;
        logic [23:0] irq_st;
        logic [23:0] wav1;
        logic [23:0] wav2;
    } mrab_live_type;

    typedef struct packed {
        logic valid;
        logic to_status;
        logic [1:0] lane;
        logic [7:0] data;
    } mrab_irq_wr_type;

endpackage

// ===== bench/mrab_meter_model.sv
// metering side: four-phase answer, internal register page
module mrab_meter_model #(
    parameter int DELAY = 3
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic req,
    input wire mrab_pkg::mrab_cmd_type cmd,
    output logic ack,
    output logic [23:0] rdata
);
    timeunit 1ns;
    timeprecision 1ns;
    import mrab_pkg::*;
    logic [23:0] page [128]; // internal page, known pattern per address
    int cnt; // cycles spent before acknowledging
    initial for (int i = 0; i < 128; i++) page[i] = {3{1'b0, i[6:0]}};
    // ------------------------------------------------------------
    // answer: odd addresses prompt, even ones slow
    // ------------------------------------------------------------
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ack <= 1'b0;
            cnt <= 0;
            rdata <= 24'h000000;
        end else if (req && !ack) begin
            rdata <= page[cmd.addr];
            cnt <= cnt + 1;
            if (cnt == (cmd.addr[0] ? 0 : DELAY)) begin
                ack <= 1'b1;
                if (cmd.write) page[cmd.addr] <= cmd.wdata;
            end
        end else if (!req && ack) begin
            ack <= 1'b0;
            cnt <= 0;
            rdata <= ~rdata; // released: never shows the stale value
        end
    end
endmodule

// ===== bench/metering_register_access_bridge_test.sv
module metering_register_access_bridge_test;
    timeunit 1ns;
    timeprecision 1ns;
    import mrab_pkg::*;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    mrab_sfr_type sfr = '0;
    mrab_live_type live = {24'h112233, 24'h445566, 24'h778899,
        24'hAABBCC, 24'hDDEEF1, 24'h021324};
    logic [7:0] rdata, got;
    logic req, ack;
    logic [23:0] mrd;
    mrab_cmd_type cmd;
    mrab_irq_wr_type irq, seen;
    int failures = 0;
    int samples_checked = 0;
    mrab_bridge dut (.clk(clk), .reset_n(reset_n), .sfr_in(sfr),
        .sfr_rdata_r(rdata), .meter_req_r(req), .meter_cmd_r(cmd),
        .meter_ack(ack), .meter_rdata(mrd), .meter_live(live),
        .irq_wr_r(irq));
    mrab_meter_model #(.DELAY(3)) far (.clk(clk), .reset_n(reset_n),
        .req(req), .cmd(cmd), .ack(ack), .rdata(mrd));
    initial forever #25 clk = ~clk;
    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] g, input logic [31:0] e);
        samples_checked++;
        if (g !== e) begin
            failures++;
            $display("[FAIL] %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    // one bus access; strobe drops for a cycle so none is doubled
    task automatic acc(input logic r, input logic [7:0] a,
        input logic [7:0] d);
        sfr = '{addr: a, wr: !r, rd: r, wdata: d};
        cyc(1);
        sfr = '0;
        got = rdata;
        seen = irq;
        cyc(1);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        acc(1'b1, a, 8'h00);
        check(got, e);
    endtask
    // pointer write, then the software wait on the handshake
    task automatic launch(input logic [7:0] p, input logic [31:0] e);
        acc(1'b0, ADDR_POINTER, p);
        check(cmd, e);
        for (int n = 0; req === 1'b1; n++) begin
            if (n == 60) begin
                failures++;
                close_out();
            end
            cyc(1);
        end
        cyc(6);
    endtask
    task automatic close_out();
        $display("checked %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_capture();
        logic [23:0] w;
        logic [7:0] b [4] = '{8'hD1, 8'hD4, 8'hE2, 8'hE5};
        int s [4] = '{0, 1, 4, 5};
        for (int k = 0; k < 4; k++) begin
            w = live[143 - 24 * s[k] -: 24];
            rd(b[k], 8'h00);
            rd(b[k] + 8'h2, w[23:16]);
            live = ~live; // later reads must still see the capture
            cyc(3);
            rd(b[k] + 8'h1, w[15:8]);
            rd(b[k], w[7:0]);
        end
        rd(8'h95, 8'h00);
    endtask
    task automatic t_irq();
        for (int k = 0; k < 6; k++) begin
            acc(1'b0, 8'hD9 + 8'(k), 8'hC0 + 8'(k));
            check(seen, {1'b1, 1'(k > 2), 2'(k % 3),
                8'hC0 + 8'(k)});
            rd(8'hD9 + 8'(k), live[(k < 3 ? 79 : 31) + 8 * k -: 8]);
            live = ~live;
            cyc(3);
        end
    endtask
    task automatic t_indirect();
        acc(1'b0, ADDR_DATA_MID, 8'h01);
        acc(1'b0, ADDR_DATA_LOW, 8'h55);
        acc(1'b0, ADDR_DATA_HIGH, 8'h7E);
        rd(ADDR_DATA_HIGH, 8'h7E);
        launch(8'h94, {1'b1, 7'h14, 24'h7E0155});
        rd(ADDR_POINTER, 8'h94);
        launch(8'h16, {1'b0, 7'h16, 24'h7E0155});
        rd(ADDR_DATA_MID, 8'h16);
        launch(8'h14, {1'b0, 7'h14, 24'h161616});
        rd(ADDR_DATA_LOW, 8'h55);
        rd(ADDR_DATA_HIGH, 8'h7E);
        launch(8'h8B, {1'b1, 7'h0B, 24'h000055});
        launch(8'h0C, {1'b0, 7'h0C, 24'h000055});
        rd(ADDR_DATA_LOW, 8'h0C);
        rd(ADDR_DATA_HIGH, 8'h00);
        acc(1'b0, ADDR_POINTER, 8'h80);
        cyc(3);
        check(req, 1'b0);
    endtask
    initial begin
        cyc(2);
        reset_n = 1'b1;
        cyc(1);
        t_capture();
        t_irq();
        t_indirect();
        close_out();
    end
endmodule
